// File: common/drf_pkg.sv
// Shared types and constants of the DSP register file.
// Assumes one core clock and that the pipeline and address unit share it.
package drf_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int DRF_DATA_W = 32;
  localparam int DRF_GUARD_W = 8;
  localparam int DRF_ACC_W = DRF_DATA_W + DRF_GUARD_W;
  localparam int DRF_HALF_W = 16;
  localparam int DRF_STATUS_W = 8;
  localparam int DRF_RSV_W = DRF_DATA_W - DRF_STATUS_W;
  localparam logic [DRF_DATA_W-1:0] DRF_WORD_RST = 32'h0000_0000;
  localparam logic [DRF_ACC_W-1:0] DRF_ACC_RST = 40'h00_0000_0000;
  localparam logic [DRF_RSV_W-1:0] DRF_RSV_ZERO = 24'h00_0000;

  // ==========================================================
  // Condition select encodings
  localparam logic [2:0] DRF_CS_CARRY = 3'h0;
  localparam logic [2:0] DRF_CS_NEG = 3'h1;
  localparam logic [2:0] DRF_CS_ZERO = 3'h2;
  localparam logic [2:0] DRF_CS_OVF = 3'h3;
  localparam logic [2:0] DRF_CS_SGT = 3'h4;
  localparam logic [2:0] DRF_CS_SGE = 3'h5;

  // ==========================================================
  // Status word, low byte; upper bits are never stored
  typedef struct packed {
    logic signed_greater_flag;
    logic zero_flag;
    logic negative_flag;
    logic overflow_flag;
    logic [2:0] cond_select;
    logic dsp_condition_flag;
  } drf_status_type;

  localparam drf_status_type DRF_STATUS_RST = 8'h00;

  typedef struct packed {
    logic [DRF_HALF_W-1:0] buffer_end_address;
    logic [DRF_HALF_W-1:0] buffer_first_address;
  } drf_bounds_type;

  // Result conditions reported by the execution pipeline
  typedef struct packed {
    logic carry;
    logic negative;
    logic zero;
    logic overflow;
    logic signed_greater;
  } drf_result_flags_type;

  // ==========================================================
  // Instruction classes and destinations
  typedef enum logic [2:0] {
    DRF_OP_DATA_PROC,
    DRF_OP_PARALLEL_SIGNED_MULTIPLY,
    DRF_OP_PARALLEL_ADD_VARIANT,
    DRF_OP_PARALLEL_SUBTRACT_VARIANT,
    DRF_OP_XSIDE_TRANSFER,
    DRF_OP_YSIDE_TRANSFER,
    DRF_OP_SINGLE_TRANSFER
  } drf_op_kind_type;

  typedef enum logic [1:0] {
    DRF_COND_ALWAYS,
    DRF_COND_IF_SET,
    DRF_COND_IF_CLEAR
  } drf_cond_kind_type;

  typedef enum logic [3:0] {
    DRF_DST_NONE,
    DRF_DST_ACCUM_FIRST,
    DRF_DST_ACCUM_SECOND,
    DRF_DST_MULT_FIRST,
    DRF_DST_MULT_SECOND,
    DRF_DST_XSIDE_FIRST,
    DRF_DST_XSIDE_SECOND,
    DRF_DST_YSIDE_FIRST,
    DRF_DST_YSIDE_SECOND
  } drf_dest_type;

  typedef struct packed {
    logic valid;
    drf_op_kind_type op_kind;
    drf_cond_kind_type cond_kind;
    drf_dest_type dest;
    logic [DRF_ACC_W-1:0] data;
    drf_result_flags_type flags;
  } drf_dsp_op_type;

  // System register selection from the core
  typedef enum logic [3:0] {
    DRF_SYS_STATUS,
    DRF_SYS_ACCUM_FIRST,
    DRF_SYS_ACCUM_SECOND,
    DRF_SYS_XSIDE_FIRST,
    DRF_SYS_XSIDE_SECOND,
    DRF_SYS_YSIDE_FIRST,
    DRF_SYS_YSIDE_SECOND,
    DRF_SYS_LOOP_FIRST,
    DRF_SYS_LOOP_LAST,
    DRF_SYS_BOUNDS
  } drf_sysreg_type;

  typedef enum logic [1:0] {
    DRF_XFER_NONE,
    DRF_XFER_XSIDE,
    DRF_XFER_YSIDE,
    DRF_XFER_SINGLE
  } drf_xfer_type;

  // Whole register file as seen by the pipeline
  typedef struct packed {
    logic [DRF_ACC_W-1:0] accum_first;
    logic [DRF_ACC_W-1:0] accum_second;
    logic [DRF_DATA_W-1:0] multiplier_operand_first;
    logic [DRF_DATA_W-1:0] multiplier_operand_second;
    logic [DRF_DATA_W-1:0] xside_operand_first;
    logic [DRF_DATA_W-1:0] xside_operand_second;
    logic [DRF_DATA_W-1:0] yside_operand_first;
    logic [DRF_DATA_W-1:0] yside_operand_second;
    logic [DRF_DATA_W-1:0] loop_first_address;
    logic [DRF_DATA_W-1:0] loop_last_address;
    drf_bounds_type circular_buffer_bounds;
    drf_status_type status;
  } drf_regs_type;

endpackage : drf_pkg

// File: src/drf_cond_eval.sv
// Condition flag evaluation for the status word.
// Assumes flags come from the same clock domain; purely combinational.
`timescale 1ns/1ps
module drf_cond_eval (
  // Selection and previous flag
  input wire logic [2:0] cond_select,
  input wire logic prev_flag,
  // Result conditions
  input wire drf_pkg::drf_result_flags_type flags,
  // New flag
  output logic cond_flag
);
  import drf_pkg::*;

  // ==========================================================
  // Mode decode
  always_comb begin
    unique case (cond_select)
      DRF_CS_CARRY: cond_flag = flags.carry;
      DRF_CS_NEG: cond_flag = flags.negative;
      DRF_CS_ZERO: cond_flag = flags.zero;
      DRF_CS_OVF: cond_flag = flags.overflow;
      DRF_CS_SGT: cond_flag = flags.signed_greater;
      // Equal counts as met, so zero joins greater
      DRF_CS_SGE: cond_flag = flags.signed_greater | flags.zero;
      default: cond_flag = prev_flag;
    endcase
  end

endmodule : drf_cond_eval

// File: src/drf_register_file.sv
// DSP data, status and loop/circular control registers of the core.
// Assumes the pipeline presents one writeback per cycle and the core
// issues system register transfers on the same clock.
`timescale 1ns/1ps
// Notes on behaviour
// - Two 40-bit accumulators with eight guard bits
// - Six 32-bit operand registers for DSP
// - Status bits 31..8 read zero, written zero
// - Bit 7 set on positive or greater
// - Bit 6 set on zero or equal
// - Bit 5 set on negative or smaller
// - Bit 4 set on overflow
// - Bits 3..1 choose condition flag source
// - Bit 0 shows chosen condition met
// - Unconditional processing updates flags, listed ops don't
// - Conditional ops gated by flag, never touch status
// - Gating touches DSP registers only, not core
// - Status word is core system register
// - Core reaches accumulators and X/Y operands
// - Loops use count, first and last registers
// - Loop addresses passed raw, not physical addresses
// - Bounds: end high half, start low half
// - Circular only for X/Y transfers, never single
module drf_register_file #(
  parameter int COUNT_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // System register transfers from the core
  input wire logic sysreg_wr,
  input wire logic sysreg_rd,
  input wire drf_pkg::drf_sysreg_type sysreg_sel,
  input wire logic [drf_pkg::DRF_DATA_W-1:0] sysreg_wdata,
  output logic [drf_pkg::DRF_DATA_W-1:0] sysreg_rdata_r,
  output logic sysreg_rvalid_r,
  // DSP pipeline writeback
  input wire drf_pkg::drf_dsp_op_type dsp_op,
  output logic dsp_exec_r,
  // Address unit and processor status word fields
  input wire drf_pkg::drf_xfer_type xfer_kind,
  input wire logic xside_circular_enable,
  input wire logic yside_circular_enable,
  input wire logic [COUNT_W-1:0] loop_iteration_count,
  output logic circ_xside_active_r,
  output logic circ_yside_active_r,
  output logic [COUNT_W-1:0] loop_count_r,
  // Register contents
  output drf_pkg::drf_regs_type regs_r
);
  import drf_pkg::*;

  // ==========================================================
  // Declarations
  drf_regs_type regs_nxt;
  logic [DRF_DATA_W-1:0] sysreg_rdata_nxt;
  logic sysreg_rvalid_nxt;
  logic dsp_exec_nxt;
  logic circ_xside_nxt;
  logic circ_yside_nxt;
  logic [COUNT_W-1:0] loop_count_nxt;
  logic permit;
  logic flag_upd;
  logic cond_flag_new;
  logic status_wr;

  // ==========================================================
  // Condition flag source
  drf_cond_eval u_cond (
    .cond_select(regs_r.status.cond_select),
    .prev_flag(regs_r.status.dsp_condition_flag),
    .flags(dsp_op.flags),
    .cond_flag(cond_flag_new)
  );

  // ==========================================================
  // Register next state
  always_comb begin
    regs_nxt = regs_r;
    status_wr = sysreg_wr && (sysreg_sel == DRF_SYS_STATUS);
    unique case (dsp_op.cond_kind)
      DRF_COND_IF_SET: permit = regs_r.status.dsp_condition_flag;
      DRF_COND_IF_CLEAR: permit = !regs_r.status.dsp_condition_flag;
      default: permit = 1'b1;
    endcase
    dsp_exec_nxt = dsp_op.valid && permit;
    flag_upd = dsp_op.valid && (dsp_op.cond_kind == DRF_COND_ALWAYS) &&
               (dsp_op.op_kind == DRF_OP_DATA_PROC);
    if (dsp_exec_nxt) begin
      unique case (dsp_op.dest)
        DRF_DST_ACCUM_FIRST: regs_nxt.accum_first = dsp_op.data;
        DRF_DST_ACCUM_SECOND: regs_nxt.accum_second = dsp_op.data;
        DRF_DST_MULT_FIRST:
          regs_nxt.multiplier_operand_first = dsp_op.data[DRF_DATA_W-1:0];
        DRF_DST_MULT_SECOND:
          regs_nxt.multiplier_operand_second = dsp_op.data[DRF_DATA_W-1:0];
        DRF_DST_XSIDE_FIRST:
          regs_nxt.xside_operand_first = dsp_op.data[DRF_DATA_W-1:0];
        DRF_DST_XSIDE_SECOND:
          regs_nxt.xside_operand_second = dsp_op.data[DRF_DATA_W-1:0];
        DRF_DST_YSIDE_FIRST:
          regs_nxt.yside_operand_first = dsp_op.data[DRF_DATA_W-1:0];
        DRF_DST_YSIDE_SECOND:
          regs_nxt.yside_operand_second = dsp_op.data[DRF_DATA_W-1:0];
        default: begin
        end
      endcase
    end
    // core transfers never gated by flag
    if (sysreg_wr) begin
      // Core write is the later instruction, so it wins the register, except the status flag bits that a flag update sets below
      unique case (sysreg_sel)
        DRF_SYS_STATUS:
          regs_nxt.status = drf_status_type'(sysreg_wdata[DRF_STATUS_W-1:0]);
        DRF_SYS_ACCUM_FIRST:
          regs_nxt.accum_first = {{DRF_GUARD_W{sysreg_wdata[DRF_DATA_W-1]}},
                                  sysreg_wdata};
        DRF_SYS_ACCUM_SECOND:
          regs_nxt.accum_second = {{DRF_GUARD_W{sysreg_wdata[DRF_DATA_W-1]}},
                                   sysreg_wdata};
        DRF_SYS_XSIDE_FIRST: regs_nxt.xside_operand_first = sysreg_wdata;
        DRF_SYS_XSIDE_SECOND: regs_nxt.xside_operand_second = sysreg_wdata;
        DRF_SYS_YSIDE_FIRST: regs_nxt.yside_operand_first = sysreg_wdata;
        DRF_SYS_YSIDE_SECOND: regs_nxt.yside_operand_second = sysreg_wdata;
        DRF_SYS_LOOP_FIRST: regs_nxt.loop_first_address = sysreg_wdata;
        DRF_SYS_LOOP_LAST: regs_nxt.loop_last_address = sysreg_wdata;
        DRF_SYS_BOUNDS:
          regs_nxt.circular_buffer_bounds = drf_bounds_type'(sysreg_wdata);
        default: begin
        end
      endcase
    end
    // Result flags override a same-cycle core write so no event is lost
    if (flag_upd) begin
      regs_nxt.status.signed_greater_flag = dsp_op.flags.signed_greater;
      regs_nxt.status.zero_flag = dsp_op.flags.zero;
      regs_nxt.status.negative_flag = dsp_op.flags.negative;
      regs_nxt.status.overflow_flag = dsp_op.flags.overflow;
      regs_nxt.status.dsp_condition_flag = cond_flag_new;
    end
  end

  // ==========================================================
  // Readback and address unit outputs
  always_comb begin
    sysreg_rvalid_nxt = sysreg_rd;
    sysreg_rdata_nxt = DRF_WORD_RST;
    if (sysreg_rd) begin
      unique case (sysreg_sel)
        DRF_SYS_STATUS: sysreg_rdata_nxt = {DRF_RSV_ZERO, regs_r.status};
        DRF_SYS_ACCUM_FIRST:
          sysreg_rdata_nxt = regs_r.accum_first[DRF_DATA_W-1:0];
        DRF_SYS_ACCUM_SECOND:
          sysreg_rdata_nxt = regs_r.accum_second[DRF_DATA_W-1:0];
        DRF_SYS_XSIDE_FIRST: sysreg_rdata_nxt = regs_r.xside_operand_first;
        DRF_SYS_XSIDE_SECOND: sysreg_rdata_nxt = regs_r.xside_operand_second;
        DRF_SYS_YSIDE_FIRST: sysreg_rdata_nxt = regs_r.yside_operand_first;
        DRF_SYS_YSIDE_SECOND: sysreg_rdata_nxt = regs_r.yside_operand_second;
        DRF_SYS_LOOP_FIRST: sysreg_rdata_nxt = regs_r.loop_first_address;
        DRF_SYS_LOOP_LAST: sysreg_rdata_nxt = regs_r.loop_last_address;
        DRF_SYS_BOUNDS: sysreg_rdata_nxt = regs_r.circular_buffer_bounds;
        default: sysreg_rdata_nxt = DRF_WORD_RST;
      endcase
    end
    // count and raw addresses go to fetch unchanged
    loop_count_nxt = loop_iteration_count;
    circ_xside_nxt = (xfer_kind == DRF_XFER_XSIDE) && xside_circular_enable;
    circ_yside_nxt = (xfer_kind == DRF_XFER_YSIDE) && yside_circular_enable;
  end

  // ==========================================================
  // State registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r <= '{accum_first: DRF_ACC_RST, accum_second: DRF_ACC_RST,
                  circular_buffer_bounds: DRF_WORD_RST,
                  status: DRF_STATUS_RST, default: DRF_WORD_RST};
      sysreg_rdata_r <= DRF_WORD_RST;
      sysreg_rvalid_r <= 1'b0;
      dsp_exec_r <= 1'b0;
      circ_xside_active_r <= 1'b0;
      circ_yside_active_r <= 1'b0;
      loop_count_r <= '0;
    end else begin
      regs_r <= regs_nxt;
      sysreg_rdata_r <= sysreg_rdata_nxt;
      sysreg_rvalid_r <= sysreg_rvalid_nxt;
      dsp_exec_r <= dsp_exec_nxt;
      circ_xside_active_r <= circ_xside_nxt;
      circ_yside_active_r <= circ_yside_nxt;
      loop_count_r <= loop_count_nxt;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  status_read_zero_a: assert property (
    sysreg_rd && sysreg_sel == DRF_SYS_STATUS |=>
      sysreg_rvalid_r && sysreg_rdata_r[DRF_DATA_W-1:DRF_STATUS_W] == '0)
    else $error("status upper bits not zero");

  greater_flag_a: assert property (
    flag_upd |=> regs_r.status.signed_greater_flag ==
                 $past(dsp_op.flags.signed_greater))
    else $error("greater flag not taken");

  zero_flag_a: assert property (
    flag_upd |=> regs_r.status.zero_flag == $past(dsp_op.flags.zero))
    else $error("zero flag not taken");

  negative_flag_a: assert property (
    flag_upd |=> regs_r.status.negative_flag == $past(dsp_op.flags.negative))
    else $error("negative flag not taken");

  overflow_flag_a: assert property (
    flag_upd |=> regs_r.status.overflow_flag == $past(dsp_op.flags.overflow))
    else $error("overflow flag not taken");

  cond_zero_mode_a: assert property (
    flag_upd && regs_r.status.cond_select == DRF_CS_ZERO |=>
      regs_r.status.dsp_condition_flag == $past(dsp_op.flags.zero))
    else $error("condition flag wrong in zero mode");

  noflag_ops_a: assert property (
    dsp_op.valid && dsp_op.op_kind != DRF_OP_DATA_PROC && !status_wr |=>
      $stable(regs_r.status))
    else $error("listed op changed status");

  cond_status_a: assert property (
    dsp_op.valid && dsp_op.cond_kind != DRF_COND_ALWAYS && !status_wr |=>
      $stable(regs_r.status))
    else $error("conditional op changed status");

  cond_skip_a: assert property (
    dsp_op.valid && !permit && !sysreg_wr |=>
      !dsp_exec_r && $stable(regs_r))
    else $error("skipped op wrote a register");

  bounds_split_a: assert property (
    sysreg_wr && sysreg_sel == DRF_SYS_BOUNDS |=>
      regs_r.circular_buffer_bounds.buffer_end_address ==
        $past(sysreg_wdata[DRF_DATA_W-1:DRF_HALF_W]))
    else $error("bounds end half wrong");

  single_circ_a: assert property (
    xfer_kind == DRF_XFER_SINGLE |=>
      !circ_xside_active_r && !circ_yside_active_r)
    else $error("single transfer made circular");

  guard_fill_a: assert property (
    sysreg_wr && sysreg_sel == DRF_SYS_ACCUM_FIRST |=>
      regs_r.accum_first == {{DRF_GUARD_W{$past(sysreg_wdata[DRF_DATA_W-1])}},
                             $past(sysreg_wdata)})
    else $error("guard bits not sign filled");

  reserved_hold_a: assert property (
    flag_upd && regs_r.status.cond_select > DRF_CS_SGE |=>
      $stable(regs_r.status.dsp_condition_flag))
    else $error("reserved select changed flag");

endmodule : drf_register_file

// File: test/drf_core_model.sv
// Behavioural model of the core pipeline and system register port.
// Assumes the register file samples every input on the rising sys_clk.
`timescale 1ns/1ps
module drf_core_model #(
  parameter int COUNT_W = 12
) (
  // Clock and answers
  input wire logic sys_clk,
  input wire logic sysreg_rvalid_r,
  input wire logic [drf_pkg::DRF_DATA_W-1:0] sysreg_rdata_r,
  // System register requests
  output logic sysreg_wr,
  output logic sysreg_rd,
  output drf_pkg::drf_sysreg_type sysreg_sel,
  output logic [drf_pkg::DRF_DATA_W-1:0] sysreg_wdata,
  // Pipeline and address unit
  output drf_pkg::drf_dsp_op_type dsp_op,
  output drf_pkg::drf_xfer_type xfer_kind,
  output logic xside_circular_enable,
  output logic yside_circular_enable,
  output logic [COUNT_W-1:0] loop_iteration_count
);
  import drf_pkg::*;

  initial begin
    sysreg_wr = 1'b0;
    sysreg_rd = 1'b0;
    sysreg_sel = DRF_SYS_STATUS;
    sysreg_wdata = '0;
    dsp_op = '0;
    xfer_kind = DRF_XFER_NONE;
    xside_circular_enable = 1'b0;
    yside_circular_enable = 1'b0;
    loop_iteration_count = '0;
  end

  // ==========================================================
  // System register transfers
  // upper status bits written zero
  // select codes come from the caller; only one test uses 110
  task automatic sys_write(input drf_sysreg_type sel,
    input logic [DRF_DATA_W-1:0] data);
    @(posedge sys_clk);
    sysreg_wr <= 1'b1;
    sysreg_sel <= sel;
    sysreg_wdata <= (sel == DRF_SYS_STATUS) ? {DRF_RSV_ZERO, data[7:0]}
      : data;
    @(posedge sys_clk);
    sysreg_wr <= 1'b0;
    sysreg_wdata <= ~sysreg_wdata;
    #1;
  endtask : sys_write

  task automatic sys_read(input drf_sysreg_type sel,
    output logic [DRF_DATA_W-1:0] data, output logic ok);
    @(posedge sys_clk);
    sysreg_rd <= 1'b1;
    sysreg_sel <= sel;
    @(posedge sys_clk);
    sysreg_rd <= 1'b0;
    #1;
    data = sysreg_rdata_r;
    ok = sysreg_rvalid_r;
  endtask : sys_read

  // ==========================================================
  // Pipeline writeback, one op then a gap
  task automatic dsp_issue(input drf_op_kind_type kind,
    input drf_cond_kind_type cond, input drf_dest_type dest,
    input logic [DRF_ACC_W-1:0] data, input logic [4:0] flags);
    drf_dsp_op_type op;
    op.valid = 1'b1;
    op.op_kind = kind;
    op.cond_kind = cond;
    op.dest = dest;
    op.data = data;
    op.flags = flags;
    @(posedge sys_clk);
    dsp_op <= op;
    @(posedge sys_clk);
    dsp_op.valid <= 1'b0;
    dsp_op.data <= ~op.data;
    #1;
  endtask : dsp_issue

  // Address unit request; never both circular enables
  task automatic addr(input drf_xfer_type k, input logic xe,
    input logic ye, input logic [COUNT_W-1:0] cnt);
    @(posedge sys_clk);
    xfer_kind <= k;
    xside_circular_enable <= xe;
    yside_circular_enable <= ye & ~xe;
    loop_iteration_count <= cnt;
    @(posedge sys_clk);
    xfer_kind <= DRF_XFER_NONE;
    #1;
  endtask : addr
endmodule : drf_core_model

// File: test/testbench.sv
// Self-checking bench of the DSP register file.
// Assumes the core model drives all inputs except clock and reset on the rising clock.
`timescale 1ns/1ps
module testbench;
  import drf_pkg::*;
  localparam int COUNT_W = 12;
  logic sys_clk, rst_n, sysreg_wr, sysreg_rd, sysreg_rvalid_r;
  drf_sysreg_type sysreg_sel;
  logic [DRF_DATA_W-1:0] sysreg_wdata, sysreg_rdata_r, d;
  drf_dsp_op_type dsp_op;
  logic dsp_exec_r, xen, yen, circ_x, circ_y, ok;
  drf_xfer_type xfer_kind;
  logic [COUNT_W-1:0] cnt, loop_count_r;
  drf_regs_type regs_r;
  int failures = 0;
  int num_checks = 0;

  drf_register_file #(.COUNT_W(COUNT_W)) uut (.sys_clk, .rst_n,
    .sysreg_wr, .sysreg_rd, .sysreg_sel, .sysreg_wdata, .sysreg_rdata_r,
    .sysreg_rvalid_r, .dsp_op, .dsp_exec_r, .xfer_kind,
    .xside_circular_enable(xen), .yside_circular_enable(yen),
    .loop_iteration_count(cnt), .circ_xside_active_r(circ_x),
    .circ_yside_active_r(circ_y), .loop_count_r, .regs_r);
  drf_core_model #(.COUNT_W(COUNT_W)) cm (.sys_clk, .sysreg_rvalid_r,
    .sysreg_rdata_r, .sysreg_wr, .sysreg_rd, .sysreg_sel, .sysreg_wdata,
    .dsp_op, .xfer_kind, .xside_circular_enable(xen),
    .yside_circular_enable(yen), .loop_iteration_count(cnt));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [39:0] got, input logic [39:0] exp,
    input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic [39:0] st_exp(input logic [4:0] f,
    input logic [2:0] sel, input logic met);
    return 40'({f[0], f[2], f[3], f[1], sel, met});
  endfunction : st_exp

  // ==========================================================
  // Scenarios
  task automatic t_acc;
    cm.sys_write(DRF_SYS_ACCUM_FIRST, 32'h8000_0000);
    chk(regs_r.accum_first, 40'hFF_8000_0000, "acc sign");
    cm.sys_write(DRF_SYS_ACCUM_SECOND, 32'h7FFF_FFFF);
    chk(regs_r.accum_second, 40'h00_7FFF_FFFF, "acc pos");
    cm.sys_read(DRF_SYS_ACCUM_FIRST, d, ok);
    chk(40'({ok, d}), 40'h1_8000_0000, "acc read");
    for (int i = 0; i < 4; i++) begin
      cm.sys_write(drf_sysreg_type'(3 + i), 32'hA500_0000 + i);
      cm.sys_read(drf_sysreg_type'(3 + i), d, ok);
      chk(40'({ok, d}), 40'h1_A500_0000 + i, "xy read");
    end
    $display("accum and operand access done");
  endtask : t_acc

  task automatic t_status;
    cm.sys_write(DRF_SYS_STATUS, 32'h5A);
    cm.sys_read(DRF_SYS_STATUS, d, ok);
    chk(40'({ok, d}), 40'h1_0000_005A, "status read");
    $display("status access done");
  endtask : t_status

  // Select codes 0 to 5 once each, met and not met
  task automatic t_cond;
    logic [4:0] on, off;
    for (int i = 0; i < 6; i++) begin
      on = (i == 5) ? 5'h04 : 5'h10 >> i;
      off = (i == 5) ? 5'h1A : ~on;
      cm.sys_write(DRF_SYS_STATUS, 32'(2 * i));
      cm.dsp_issue(DRF_OP_DATA_PROC, DRF_COND_ALWAYS,
        DRF_DST_XSIDE_FIRST, 40'h11_2233_4400 + i, on);
      chk(40'(regs_r.status), st_exp(on, 3'(i), 1'b1), "cond met");
      chk(40'(regs_r.xside_operand_first), 40'h2233_4400 + i, "dst");
      chk(40'(dsp_exec_r), 40'h1, "exec");
      cm.dsp_issue(DRF_OP_DATA_PROC, DRF_COND_ALWAYS,
        DRF_DST_XSIDE_FIRST, 40'h0, off);
      chk(40'(regs_r.status), st_exp(off, 3'(i), 1'b0), "cond miss");
    end
    $display("condition modes done");
  endtask : t_cond

  // Listed ops keep every status bit
  task automatic t_noflag;
    cm.sys_write(DRF_SYS_STATUS, 32'h44);
    for (int k = 1; k < 7; k++) begin
      cm.dsp_issue(drf_op_kind_type'(k), DRF_COND_ALWAYS,
        DRF_DST_MULT_FIRST, 40'h00_0BAD_0000 + k, 5'h1F);
      chk(40'(regs_r.status), 40'h44, "status kept");
      chk(40'(regs_r.multiplier_operand_first), 40'h0BAD_0000 + k, "m");
    end
    cm.dsp_issue(DRF_OP_PARALLEL_ADD_VARIANT, DRF_COND_ALWAYS,
      DRF_DST_ACCUM_SECOND, 40'hAB_CDEF_0123, 5'h1F);
    chk(regs_r.accum_second, 40'hAB_CDEF_0123, "acc 40 bit");
    cm.dsp_issue(DRF_OP_PARALLEL_SIGNED_MULTIPLY, DRF_COND_ALWAYS,
      DRF_DST_MULT_SECOND, 40'h00_0C0D_E000, 5'h1F);
    chk(40'(regs_r.multiplier_operand_second), 40'h0C0D_E000, "m2");
    chk(40'(regs_r.status), 40'h44, "status kept 2");
    $display("flag-neutral ops done");
  endtask : t_noflag

  task automatic t_gate;
    cm.sys_write(DRF_SYS_STATUS, 32'h05);
    cm.dsp_issue(DRF_OP_DATA_PROC, DRF_COND_IF_SET,
      DRF_DST_YSIDE_FIRST, 40'h00_1357_9BDF, 5'h1F);
    chk(40'(regs_r.yside_operand_first), 40'h1357_9BDF, "if set");
    chk(40'({dsp_exec_r, regs_r.status}), 40'h105, "set status");
    cm.dsp_issue(DRF_OP_DATA_PROC, DRF_COND_IF_CLEAR,
      DRF_DST_YSIDE_SECOND, 40'h00_2468_ACE0, 5'h1F);
    chk(40'(regs_r.yside_operand_second), 40'hA500_0003, "if clr");
    chk(40'({dsp_exec_r, regs_r.status}), 40'h005, "clr status");
    cm.sys_write(DRF_SYS_YSIDE_SECOND, 32'h0000_7777);
    chk(40'(regs_r.yside_operand_second), 40'h7777, "core wr");
    $display("conditional ops done");
  endtask : t_gate

  // Reserved select on purpose: flag must hold
  task automatic t_rsv;
    cm.sys_write(DRF_SYS_STATUS, 32'h0D);
    cm.dsp_issue(DRF_OP_DATA_PROC, DRF_COND_ALWAYS,
      DRF_DST_XSIDE_SECOND, 40'h1, 5'h04);
    chk(40'(regs_r.status), 40'h4D, "rsv keeps flag");
    $display("reserved select done");
  endtask : t_rsv

  task automatic t_ctl;
    cm.sys_write(DRF_SYS_BOUNDS, 32'h1234_ABCD);
    chk(40'(regs_r.circular_buffer_bounds), 40'h1234_ABCD, "bounds");
    cm.sys_read(DRF_SYS_BOUNDS, d, ok);
    chk(40'({ok, d}), 40'h1_1234_ABCD, "bounds read");
    cm.sys_write(DRF_SYS_LOOP_FIRST, 32'h0000_0102);
    chk(40'(regs_r.loop_first_address), 40'h102, "loop first");
    cm.sys_write(DRF_SYS_LOOP_LAST, 32'h0000_0203);
    cm.sys_read(DRF_SYS_LOOP_LAST, d, ok);
    chk(40'({ok, d}), 40'h1_0000_0203, "loop last");
    cm.addr(DRF_XFER_XSIDE, 1'b1, 1'b0, 12'hA5C);
    chk(40'({circ_x, circ_y, loop_count_r}), 40'h2A5C, "x circ");
    cm.addr(DRF_XFER_YSIDE, 1'b0, 1'b1, 12'h001);
    chk(40'({circ_x, circ_y}), 40'h1, "y circ");
    cm.addr(DRF_XFER_SINGLE, 1'b1, 1'b0, 12'h001);
    chk(40'({circ_x, circ_y}), 40'h0, "single");
    cm.addr(DRF_XFER_XSIDE, 1'b0, 1'b0, 12'h001);
    chk(40'({circ_x, circ_y}), 40'h0, "x off");
    $display("loop and circular control done");
  endtask : t_ctl

  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk(40'(|regs_r), 40'h0, "reset regs");
    chk(40'({sysreg_rvalid_r, dsp_exec_r, circ_x, circ_y}), 40'h0,
      "reset outs");
    t_acc();
    t_status();
    t_cond();
    t_noflag();
    t_gate();
    t_rsv();
    t_ctl();
    wrap_up();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up();
  end
endmodule : testbench
